/* logic/tpr_defines.vh */
// register offsets, field positions, reset values and decode constants
// of the touch pattern detector and the recalibration control block.
// assumes inclusion by bare name from the design files only.
`ifndef TPR_DEFINES_VH
`define TPR_DEFINES_VH

// register offsets
`define TPR_ADDR_MAIN_CTRL 8'h00
`define TPR_ADDR_STATUS 8'h02
`define TPR_ADDR_PAT_MASK 8'h2d
`define TPR_ADDR_PAT_CFG 8'h2e
`define TPR_ADDR_RECAL_CFG 8'h2f
`define TPR_ADDR_TH_FIRST 8'h30
`define TPR_ADDR_TH_LAST 8'h37
`define TPR_ADDR_STBY_TH 8'h42

// reset values
`define TPR_RST_PAT_MASK 8'hff
`define TPR_RST_PAT_CFG 8'h00
`define TPR_RST_RECAL_CFG 8'h8a
`define TPR_RST_TH 7'h40
`define TPR_RST_STBY_TH 7'h40

// main control and status fields
`define TPR_INT_BIT 0
`define TPR_STAT_PAT_BIT 2

// pattern config fields
`define TPR_PCFG_EN_BIT 7
`define TPR_PCFG_TH_HI 3
`define TPR_PCFG_TH_LO 2
`define TPR_PCFG_MODE_BIT 1
`define TPR_PCFG_ALERT_BIT 0
`define TPR_PCFG_RW_MASK 8'h8f

// recalibration config fields
`define TPR_RCFG_BCAST_BIT 7
`define TPR_RCFG_KEEP_INTD_BIT 6
`define TPR_RCFG_KEEP_NEG_BIT 5
`define TPR_RCFG_NEG_HI 4
`define TPR_RCFG_NEG_LO 3
`define TPR_RCFG_CAL_HI 2
`define TPR_RCFG_CAL_LO 0

// pattern threshold codes
`define TPR_PTH_EIGHTH 2'h0
`define TPR_PTH_QUARTER 2'h1
`define TPR_PTH_3EIGHTHS 2'h2
`define TPR_PTH_FULL 2'h3

// consecutive negative delta trigger counts
`define TPR_NEG_CNT_0 6'h08
`define TPR_NEG_CNT_1 6'h10
`define TPR_NEG_CNT_2 6'h20
`define TPR_NEG_OFF 2'h3

// recalibration decode: log2 of sample count and update periods (polling cycles)
`define TPR_CAL_MAX_SHIFT 4'h8
`define TPR_CAL_MIN_SHIFT 4'h4
`define TPR_CAL_CODE_LONG 3'h4
`define TPR_CAL_PER_5 13'h0400
`define TPR_CAL_PER_6 13'h0800
`define TPR_CAL_PER_7 13'h1000

`endif

/* logic/tpr_base_track.v */
// base count tracking for eight inputs: averages recalibration samples,
// times base updates in polling cycles and counts negative deltas.
// assumes samples arrive one input at a time from same-clock logic.
`include "tpr_defines.vh"

module tpr_base_track (
  // clock and reset
  input wire clk,
  input wire rst,
  // per-input samples
  input wire sample_valid,
  input wire [2:0] sample_idx,
  input wire signed [7:0] sample_delta,
  input wire sample_noise,
  input wire cycle_end,
  // configuration
  input wire [2:0] cal_cfg,
  input wire [1:0] neg_sel,
  input wire keep_intd,
  input wire keep_neg,
  // results
  output reg upd_valid,
  output reg [2:0] upd_idx,
  output reg signed [7:0] upd_value,
  output reg recal_valid,
  output reg [2:0] recal_idx
);

  function [3:0] cal_shift;
    input [2:0] code;
    begin
      if (code > `TPR_CAL_CODE_LONG)
        cal_shift = `TPR_CAL_MAX_SHIFT;
      else
        cal_shift = `TPR_CAL_MIN_SHIFT + {1'b0, code};
    end
  endfunction

  function [12:0] cal_period;
    input [2:0] code;
    begin
      case (code)
        3'h5: cal_period = `TPR_CAL_PER_5;
        3'h6: cal_period = `TPR_CAL_PER_6;
        3'h7: cal_period = `TPR_CAL_PER_7;
        default: cal_period = 13'h0001 << (`TPR_CAL_MIN_SHIFT + {1'b0, code});
      endcase
    end
  endfunction

  reg signed [15:0] acc [0:7];
  reg [8:0] nsamp [0:7];
  reg [5:0] negcnt [0:7];
  reg [7:0] upd_due;
  reg [12:0] per_cnt;
  reg [5:0] neg_limit;
  integer i;

  wire [3:0] shift = cal_shift(cal_cfg);
  wire [8:0] samp_goal = 9'h001 << shift;
  wire signed [15:0] cur_acc = acc[sample_idx];
  wire signed [15:0] avg = cur_acc >>> shift;

  always @* begin
    case (neg_sel)
      2'h0: neg_limit = `TPR_NEG_CNT_0;
      2'h1: neg_limit = `TPR_NEG_CNT_1;
      default: neg_limit = `TPR_NEG_CNT_2;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < 8; i = i + 1) begin
        acc[i] <= 16'sh0000;
        nsamp[i] <= 9'h000;
        negcnt[i] <= 6'h00;
      end
      upd_due <= 8'h00;
      per_cnt <= 13'h0000;
      upd_valid <= 1'b0;
      upd_idx <= 3'h0;
      upd_value <= 8'sh00;
      recal_valid <= 1'b0;
      recal_idx <= 3'h0;
    end else begin
      upd_valid <= 1'b0;
      recal_valid <= 1'b0;
      if (sample_valid) begin
        if (sample_noise) begin
          if (!keep_intd) begin
            acc[sample_idx] <= 16'sh0000;
            nsamp[sample_idx] <= 9'h000;
          end
          if (!keep_neg)
            negcnt[sample_idx] <= 6'h00;
        end else begin
          if (upd_due[sample_idx] && nsamp[sample_idx] >= samp_goal) begin
            upd_valid <= 1'b1;
            upd_idx <= sample_idx;
            upd_value <= avg[7:0];
            acc[sample_idx] <= 16'sh0000;
            nsamp[sample_idx] <= 9'h000;
            upd_due[sample_idx] <= 1'b0;
          end else if (nsamp[sample_idx] < samp_goal) begin
            acc[sample_idx] <= cur_acc + {{8{sample_delta[7]}}, sample_delta};
            nsamp[sample_idx] <= nsamp[sample_idx] + 9'h001;
          end
          if (sample_delta[7] && neg_sel != `TPR_NEG_OFF) begin
            if (negcnt[sample_idx] + 6'h01 >= neg_limit) begin
              negcnt[sample_idx] <= 6'h00;
              recal_valid <= 1'b1;
              recal_idx <= sample_idx;
            end else begin
              negcnt[sample_idx] <= negcnt[sample_idx] + 6'h01;
            end
          end else begin
            negcnt[sample_idx] <= 6'h00;
          end
        end
      end
      // update interval counted in polling cycles; a new expiry wins over
      // the due bit cleared by an update in the same cycle
      if (cycle_end) begin
        if (per_cnt + 13'h0001 >= cal_period(cal_cfg)) begin
          per_cnt <= 13'h0000;
          upd_due <= 8'hff;
        end else begin
          per_cnt <= per_cnt + 13'h0001;
        end
      end
    end
  end

endmodule // tpr_base_track

/* logic/tpr_top.v */
// touch pattern detector with its register set and recalibration control.
// assumes the serial register front end gives one-cycle read and write
// strobes, and the measurement front end gives per-input deltas, noise
// flags and an end-of-polling-cycle pulse, all on CLK.
//
// Behaviour
// - pattern detection runs only while the enable bit is one; reset zero.
// - pattern threshold scales touch threshold, or standby threshold in standby.
// - threshold code 00/01/10/11 gives 12.5/25/37.5/100 percent.
// - count mode: event when inputs over threshold or noisy reach pattern ones count.
// - pattern mode: event when every selected input is over threshold or noisy.
// - evaluation uses results of a single polling cycle only.
// - on event set status bit and block touches on all inputs.
// - alert output asserts only when alert enable set; status always set.
// - inputs stay blocked while condition holds; touches restored after.
// - status clears only by host writing zero to interrupt bit after condition.
// - pattern bits 7..0 map inputs eight..one; reset all ones.
// - broadcast bit makes input-one threshold write load all eight.
// - keep-intermediate zero clears recalibration accumulation on noise.
// - keep-negative-count zero clears negative delta counter on noise.
// - negative delta trigger after 8, 16, 32 counts, or disabled.
// - recalibration code gives sample count and update period.
// - update period counted in polling cycles; samples averaged for base.
// - touch reported when delta exceeds its input threshold, or standby threshold in standby.
`include "tpr_defines.vh"

module tpr_top (
  // clock and reset
  input wire CLK,
  input wire RST,
  // register port from the serial interface
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  output reg [7:0] REG_RDATA,
  // measurement results
  input wire SAMPLE_VALID,
  input wire [2:0] SAMPLE_IDX,
  input wire signed [7:0] SAMPLE_DELTA,
  input wire SAMPLE_NOISE,
  input wire CYCLE_END,
  input wire STANDBY,
  // detection outputs
  output reg [7:0] TOUCH,
  output reg PATTERN_BLOCK,
  output reg ALERT_N,
  // base count tracking outputs
  output reg BASE_UPD,
  output reg [2:0] BASE_IDX,
  output reg signed [7:0] BASE_ADJ,
  output reg [7:0] RECAL_REQ
);

  function [3:0] ones_count;
    input [7:0] v;
    integer k;
    begin
      ones_count = 4'h0;
      for (k = 0; k < 8; k = k + 1)
        ones_count = ones_count + {3'h0, v[k]};
    end
  endfunction

  function [6:0] scale_th;
    input [6:0] th;
    input [1:0] code;
    begin
      case (code)
        `TPR_PTH_EIGHTH: scale_th = th >> 3;
        `TPR_PTH_QUARTER: scale_th = th >> 2;
        `TPR_PTH_3EIGHTHS: scale_th = (th >> 2) + (th >> 3);
        default: scale_th = th;
      endcase
    end
  endfunction

  // delta above a threshold: only positive deltas can exceed
  function over_th;
    input signed [7:0] d;
    input [6:0] th;
    begin
      over_th = !d[7] && (d[6:0] > th);
    end
  endfunction

  // registers
  reg [7:0] touch_pattern_mask;
  reg [7:0] touch_pattern_config;
  reg [7:0] recalibration_config;
  reg [6:0] input_threshold [0:7];
  reg [6:0] standby_threshold;
  reg int_flag;
  reg pattern_event_status;

  // polling-cycle gathering
  reg [7:0] above_mask;
  reg [7:0] touch_raw;
  reg [7:0] next_above_mask;
  reg [7:0] next_touch_raw;
  reg pattern_hit;
  integer j;

  wire pattern_detect_enable = touch_pattern_config[`TPR_PCFG_EN_BIT];
  wire [1:0] pattern_threshold_select =
    touch_pattern_config[`TPR_PCFG_TH_HI:`TPR_PCFG_TH_LO];
  wire pattern_compare_mode = touch_pattern_config[`TPR_PCFG_MODE_BIT];
  wire pattern_alert_enable = touch_pattern_config[`TPR_PCFG_ALERT_BIT];
  wire threshold_broadcast_load = recalibration_config[`TPR_RCFG_BCAST_BIT];
  wire keep_intermediate_accum = recalibration_config[`TPR_RCFG_KEEP_INTD_BIT];
  wire keep_negative_count = recalibration_config[`TPR_RCFG_KEEP_NEG_BIT];
  wire [1:0] negative_delta_trigger_count =
    recalibration_config[`TPR_RCFG_NEG_HI:`TPR_RCFG_NEG_LO];
  wire [2:0] cal_cfg = recalibration_config[`TPR_RCFG_CAL_HI:`TPR_RCFG_CAL_LO];

  // base threshold for the input being sampled
  wire [6:0] base_th = STANDBY ? standby_threshold : input_threshold[SAMPLE_IDX];
  wire [6:0] pat_th = scale_th(base_th, pattern_threshold_select);

  wire wr_int = REG_WR && REG_ADDR == `TPR_ADDR_MAIN_CTRL;
  wire int_clear = wr_int && !REG_WDATA[`TPR_INT_BIT];
  wire wr_th = REG_WR && REG_ADDR >= `TPR_ADDR_TH_FIRST && REG_ADDR <= `TPR_ADDR_TH_LAST;
  wire [2:0] wr_th_idx = REG_ADDR[2:0];

  // per-input results of the current sample merged into the cycle masks
  always @* begin
    next_above_mask = above_mask;
    next_touch_raw = touch_raw;
    if (SAMPLE_VALID) begin
      next_above_mask[SAMPLE_IDX] = over_th(SAMPLE_DELTA, pat_th) || SAMPLE_NOISE;
      next_touch_raw[SAMPLE_IDX] = over_th(SAMPLE_DELTA, base_th);
    end
  end

  // pattern criterion on one polling cycle's results
  always @* begin
    if (pattern_compare_mode)
      pattern_hit = (next_above_mask & touch_pattern_mask) == touch_pattern_mask;
    else
      pattern_hit = ones_count(next_above_mask) >= ones_count(touch_pattern_mask);
    pattern_hit = pattern_hit && pattern_detect_enable;
  end

  // register writes
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      touch_pattern_mask <= `TPR_RST_PAT_MASK;
      touch_pattern_config <= `TPR_RST_PAT_CFG;
      recalibration_config <= `TPR_RST_RECAL_CFG;
      standby_threshold <= `TPR_RST_STBY_TH;
      for (j = 0; j < 8; j = j + 1)
        input_threshold[j] <= `TPR_RST_TH;
    end else if (REG_WR) begin
      case (REG_ADDR)
        `TPR_ADDR_PAT_MASK: touch_pattern_mask <= REG_WDATA;
        `TPR_ADDR_PAT_CFG: touch_pattern_config <= REG_WDATA & `TPR_PCFG_RW_MASK;
        `TPR_ADDR_RECAL_CFG: recalibration_config <= REG_WDATA;
        `TPR_ADDR_STBY_TH: standby_threshold <= REG_WDATA[6:0];
        default: begin
          if (wr_th) begin
            if (wr_th_idx == 3'h0 && threshold_broadcast_load) begin
              for (j = 0; j < 8; j = j + 1)
                input_threshold[j] <= REG_WDATA[6:0];
            end else begin
              input_threshold[wr_th_idx] <= REG_WDATA[6:0];
            end
          end
        end
      endcase
    end
  end

  // cycle gathering and end-of-cycle evaluation
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      above_mask <= 8'h00;
      touch_raw <= 8'h00;
      PATTERN_BLOCK <= 1'b0;
      TOUCH <= 8'h00;
    end else begin
      if (CYCLE_END) begin
        above_mask <= 8'h00;
        touch_raw <= 8'h00;
        PATTERN_BLOCK <= pattern_hit;
        TOUCH <= pattern_hit ? 8'h00 : next_touch_raw;
      end else begin
        above_mask <= next_above_mask;
        touch_raw <= next_touch_raw;
      end
    end
  end

  // status and interrupt flags: a new event wins over a clear
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      pattern_event_status <= 1'b0;
      int_flag <= 1'b0;
      ALERT_N <= 1'b1;
    end else begin
      if (CYCLE_END && pattern_hit)
        pattern_event_status <= 1'b1;
      else if (int_clear && !PATTERN_BLOCK)
        pattern_event_status <= 1'b0;
      if (CYCLE_END && pattern_hit && pattern_alert_enable) begin
        int_flag <= 1'b1;
        ALERT_N <= 1'b0;
      end else if (int_clear) begin
        int_flag <= 1'b0;
        ALERT_N <= 1'b1;
      end
    end
  end

  // register reads, answered on the next edge
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `TPR_ADDR_MAIN_CTRL: REG_RDATA <= {7'h00, int_flag};
        `TPR_ADDR_STATUS: REG_RDATA <= {5'h00, pattern_event_status, 2'h0};
        `TPR_ADDR_PAT_MASK: REG_RDATA <= touch_pattern_mask;
        `TPR_ADDR_PAT_CFG: REG_RDATA <= touch_pattern_config;
        `TPR_ADDR_RECAL_CFG: REG_RDATA <= recalibration_config;
        `TPR_ADDR_STBY_TH: REG_RDATA <= {1'b0, standby_threshold};
        default: REG_RDATA <= wr_th_any(REG_ADDR) ? {1'b0, input_threshold[REG_ADDR[2:0]]}
                                                 : 8'h00;
      endcase
    end
  end

  function wr_th_any;
    input [7:0] a;
    begin
      wr_th_any = a >= `TPR_ADDR_TH_FIRST && a <= `TPR_ADDR_TH_LAST;
    end
  endfunction

  // base count tracking
  wire upd_valid;
  wire [2:0] upd_idx;
  wire signed [7:0] upd_value;
  wire recal_valid;
  wire [2:0] recal_idx;

  tpr_base_track u_track (
    .clk(CLK),
    .rst(RST),
    .sample_valid(SAMPLE_VALID),
    .sample_idx(SAMPLE_IDX),
    .sample_delta(SAMPLE_DELTA),
    .sample_noise(SAMPLE_NOISE),
    .cycle_end(CYCLE_END),
    .cal_cfg(cal_cfg),
    .neg_sel(negative_delta_trigger_count),
    .keep_intd(keep_intermediate_accum),
    .keep_neg(keep_negative_count),
    .upd_valid(upd_valid),
    .upd_idx(upd_idx),
    .upd_value(upd_value),
    .recal_valid(recal_valid),
    .recal_idx(recal_idx)
  );

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      BASE_UPD <= 1'b0;
      BASE_IDX <= 3'h0;
      BASE_ADJ <= 8'sh00;
      RECAL_REQ <= 8'h00;
    end else begin
      BASE_UPD <= upd_valid;
      BASE_IDX <= upd_idx;
      BASE_ADJ <= upd_value;
      RECAL_REQ <= recal_valid ? (8'h01 << recal_idx) : 8'h00;
    end
  end

endmodule // tpr_top

/* verification/tpr_top_props.sv */
// assertion checker on the ports of the touch pattern block
// assumes one clock CLK and asynchronous active high RST
module tpr_props (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // register port
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  // measurement
  input wire logic SAMPLE_VALID,
  input wire logic [2:0] SAMPLE_IDX,
  input wire logic SAMPLE_NOISE,
  input wire logic CYCLE_END,
  // outputs
  input wire logic [7:0] TOUCH,
  input wire logic PATTERN_BLOCK,
  input wire logic ALERT_N,
  input wire logic BASE_UPD,
  input wire logic [2:0] BASE_IDX,
  input wire logic [7:0] RECAL_REQ
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  AST_BLOCK_NO_TOUCH: assert property (PATTERN_BLOCK |-> TOUCH == 8'h00)
    else $error("touch reported while blocked");
  AST_BLOCK_AT_END: assert property (!$stable(PATTERN_BLOCK) |-> $past(CYCLE_END))
    else $error("block changed away from cycle end");
  AST_TOUCH_AT_END: assert property (!$stable(TOUCH) |-> $past(CYCLE_END))
    else $error("touch changed away from cycle end");
  AST_ALERT_SET: assert property ($fell(ALERT_N) |-> $past(CYCLE_END) && PATTERN_BLOCK)
    else $error("alert without pattern event");
  AST_ALERT_CLEAR: assert property ($rose(ALERT_N) |-> $past(REG_WR)
    && $past(REG_ADDR) == 8'h00 && !$past(REG_WDATA[0]))
    else $error("alert released without host clear");
  AST_READ_ONLY_ON_RD: assert property (!$stable(REG_RDATA) |-> $past(REG_RD))
    else $error("read data moved without read");
  AST_BASE_CAUSE: assert property (BASE_UPD |-> $past(SAMPLE_VALID, 2) && !$past(SAMPLE_NOISE, 2)
    && BASE_IDX == $past(SAMPLE_IDX, 2))
    else $error("base update without clean sample");
  AST_RECAL_CAUSE: assert property (RECAL_REQ != 8'h00 |-> $past(SAMPLE_VALID, 2)
    && RECAL_REQ == 8'h01 << $past(SAMPLE_IDX, 2) ##1 RECAL_REQ == 8'h00)
    else $error("recal request malformed");
endmodule // tpr_props

bind tpr_top tpr_props props_u (.CLK, .RST, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA, .REG_RDATA,
  .SAMPLE_VALID, .SAMPLE_IDX, .SAMPLE_NOISE, .CYCLE_END, .TOUCH, .PATTERN_BLOCK, .ALERT_N,
  .BASE_UPD, .BASE_IDX, .RECAL_REQ);

/* verification/tpr_host.sv */
// host model: one-cycle register read and write strobes
// assumes a read answer registered one cycle after the read edge
module tpr_host (
  // clock
  input wire logic CLK,
  // register port
  output logic REG_WR,
  output logic REG_RD,
  output logic [7:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
  end
  // released lines show inverted values so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 1'b0;
    REG_ADDR <= ~a;
    REG_WDATA <= ~d;
    @(posedge CLK);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'b0;
    REG_ADDR <= ~a;
    repeat (2) @(posedge CLK);
    v = REG_RDATA;
  endtask
endmodule // tpr_host

/* verification/test_touch_pattern_recal_config.sv */
// bench for the touch pattern block: pattern table, then blocking,
// recalibration, base update and threshold broadcast cases
// assumes the host model owns the register port
module test_touch_pattern_recal_config;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] cfg, mask; logic stby; logic [63:0] d;
    logic [7:0] nz, blk, aln, tch;} tpr_row_t;
  logic CLK, RST, REG_WR, REG_RD, SAMPLE_VALID, SAMPLE_NOISE, CYCLE_END, STANDBY;
  logic PATTERN_BLOCK, ALERT_N, BASE_UPD;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, TOUCH, RECAL_REQ, v, rq;
  logic signed [7:0] SAMPLE_DELTA, BASE_ADJ, adj;
  logic [2:0] SAMPLE_IDX, BASE_IDX;
  int n_mismatch = 0;
  int checks = 0;
  int n_rq = 0;
  int n_bu = 0;
  int cycles = 0;
  int n0;
  logic [7:0] ra [5] = '{8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h55};
  logic [7:0] rv [5] = '{8'hff, 8'h00, 8'h8a, 8'h40, 8'h00};
  tpr_row_t rows [10] = '{
    '{8'h81, 8'h03, 1'b0, 64'h0909, 8'h00, 8'h01, 8'h00, 8'h00},
    '{8'h81, 8'h03, 1'b0, 64'h0908, 8'h00, 8'h00, 8'h01, 8'h00},
    '{8'h85, 8'h07, 1'b0, 64'h0011110000000000, 8'h80, 8'h01, 8'h00, 8'h00},
    '{8'h87, 8'h07, 1'b0, 64'h0011110000000000, 8'h80, 8'h00, 8'h01, 8'h00},
    '{8'h8b, 8'h81, 1'b0, 64'h19, 8'h80, 8'h01, 8'h00, 8'h00},
    '{8'h8b, 8'h81, 1'b0, 64'h18, 8'h80, 8'h00, 8'h01, 8'h00},
    '{8'h8c, 8'h01, 1'b0, 64'h41000000, 8'h00, 8'h01, 8'h01, 8'h00},
    '{8'h0d, 8'h01, 1'b0, 64'h41000000, 8'h00, 8'h00, 8'h01, 8'h08},
    '{8'h81, 8'h01, 1'b1, 64'h050000, 8'h00, 8'h01, 8'h00, 8'h00},
    '{8'h81, 8'h01, 1'b0, 64'hec, 8'h00, 8'h00, 8'h01, 8'h00}};

  tpr_top dut_u (.CLK, .RST, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA, .REG_RDATA,
    .SAMPLE_VALID, .SAMPLE_IDX, .SAMPLE_DELTA, .SAMPLE_NOISE, .CYCLE_END, .STANDBY,
    .TOUCH, .PATTERN_BLOCK, .ALERT_N, .BASE_UPD, .BASE_IDX, .BASE_ADJ, .RECAL_REQ);
  tpr_host host_u (.CLK, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA, .REG_RDATA);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one polling cycle: a sample per input, cycle end on the last
  task automatic cyc(input logic [63:0] d, input logic [7:0] nz);
    for (int i = 0; i < 8; i++) begin
      SAMPLE_VALID <= 1'b1;
      SAMPLE_IDX <= i[2:0];
      SAMPLE_DELTA <= d[8*i+:8];
      SAMPLE_NOISE <= nz[i];
      CYCLE_END <= (i == 7);
      @(posedge CLK);
    end
    SAMPLE_VALID <= 1'b0;
    CYCLE_END <= 1'b0;
    SAMPLE_DELTA <= ~SAMPLE_DELTA;
    @(posedge CLK);
  endtask

  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (RECAL_REQ != 8'h00) begin
      n_rq <= n_rq + 1;
      rq <= RECAL_REQ;
    end
    if (BASE_UPD && BASE_IDX == 3'h0) begin
      n_bu <= n_bu + 1;
      adj <= BASE_ADJ;
    end
    if (cycles == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    RST = 1'b1;
    STANDBY = 1'b0;
    SAMPLE_VALID = 1'b0;
    SAMPLE_NOISE = 1'b0;
    CYCLE_END = 1'b0;
    SAMPLE_IDX = 3'h0;
    SAMPLE_DELTA = 8'sh00;
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    chk({7'h00, ALERT_N}, 8'h01);
    foreach (ra[i]) begin
      host_u.rd(ra[i], v);
      chk(v, rv[i]);
    end
    $display("reset test done");
    host_u.wr(8'h42, 8'h20);
    foreach (rows[i]) begin
      STANDBY <= rows[i].stby;
      host_u.wr(8'h2e, rows[i].cfg);
      host_u.wr(8'h2d, rows[i].mask);
      cyc(rows[i].d, rows[i].nz);
      chk({7'h00, PATTERN_BLOCK}, rows[i].blk);
      chk({7'h00, ALERT_N}, rows[i].aln);
      chk(TOUCH, rows[i].tch);
      host_u.rd(8'h02, v);
      chk(v & 8'h04, rows[i].blk << 2);
      cyc(64'h0, 8'h00);
      host_u.wr(8'h00, 8'h00);
      chk({7'h00, ALERT_N}, 8'h01);
      $display("row %0d done", i);
    end
    host_u.wr(8'h2e, 8'h83);
    host_u.wr(8'h2d, 8'h01);
    cyc(64'h50, 8'h00);
    host_u.wr(8'h00, 8'h00);
    chk({7'h00, ALERT_N}, 8'h01);
    host_u.rd(8'h02, v);
    chk(v, 8'h04);
    cyc(64'h50, 8'h00);
    chk({7'h00, PATTERN_BLOCK}, 8'h01);
    cyc(64'h5000, 8'h00);
    chk(TOUCH, 8'h02);
    host_u.wr(8'h00, 8'h00);
    chk({7'h00, ALERT_N}, 8'h01);
    host_u.rd(8'h02, v);
    chk(v, 8'h00);
    $display("blocking test done");
    n0 = n_rq;
    host_u.wr(8'h2f, 8'h82);
    repeat (7) cyc(64'hff0000, 8'h00);
    cyc(64'hff0000, 8'h04);
    repeat (7) cyc(64'hff0000, 8'h00);
    chk(8'(n_rq - n0), 8'h00);
    cyc(64'hff0000, 8'h00);
    chk(8'(n_rq - n0), 8'h01);
    chk(rq, 8'h04);
    host_u.wr(8'h2f, 8'h9a);
    repeat (9) cyc(64'hff0000, 8'h00);
    chk(8'(n_rq - n0), 8'h01);
    $display("negative delta test done");
    RST <= 1'b1;
    @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    host_u.wr(8'h2f, 8'h98);
    n0 = n_bu;
    repeat (16) cyc(64'h04, 8'h00);
    chk(8'(n_bu - n0), 8'h00);
    cyc(64'h04, 8'h01);
    repeat (16) cyc(64'h04, 8'h00);
    chk(8'(n_bu - n0), 8'h00);
    cyc(64'h04, 8'h00);
    chk(8'(n_bu - n0), 8'h01);
    chk(adj, 8'h04);
    $display("base update test done");
    host_u.wr(8'h30, 8'h10);
    host_u.rd(8'h37, v);
    chk(v, 8'h10);
    host_u.wr(8'h2f, 8'h0a);
    host_u.wr(8'h30, 8'h20);
    host_u.rd(8'h31, v);
    chk(v, 8'h10);
    cyc(64'h101121, 8'h00);
    chk(TOUCH, 8'h03);
    $display("broadcast test done");
    finish_test();
  end
endmodule // test_touch_pattern_recal_config
